//--- core/mqf_core.sv
// Multi-queue store with first-word fall-through read port, queue flags and flag busses.
// Assumes host ports are driven from CLK_SYS logic and that token pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module mqf_core
#(
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [mqf_pkg::MQF_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Write port
  input wire mqf_pkg::mqf_wr_req_t WR_REQ,
  output logic ALMOST_FULL_N,
  output logic ALMOST_FULL_N_OE,
  // Read port
  input wire mqf_pkg::mqf_rd_req_t RD_REQ,
  input wire logic OUT_EN_N,
  output logic [mqf_pkg::MQF_DW-1:0] RD_DATA,
  output logic RD_DATA_OE,
  output logic OUTPUT_VALID_N,
  output logic OUTPUT_VALID_N_OE,
  output logic ALMOST_EMPTY_N,
  output logic ALMOST_EMPTY_N_OE,
  // Flag busses
  input wire mqf_pkg::mqf_bus_sel_t FULL_BUS_SEL,
  input wire mqf_pkg::mqf_bus_sel_t EMPTY_BUS_SEL,
  output logic [mqf_pkg::MQF_NQ-1:0] ALMOST_FULL_QUEUE_BUS,
  output logic ALMOST_FULL_QUEUE_BUS_OE,
  output logic [mqf_pkg::MQF_NQ-1:0] ALMOST_EMPTY_QUEUE_BUS,
  output logic ALMOST_EMPTY_QUEUE_BUS_OE,
  // Expansion
  input wire logic FULL_BUS_TOKEN_IN,
  input wire logic EMPTY_BUS_TOKEN_IN,
  output logic FULL_BUS_TOKEN_OUT,
  output logic EMPTY_BUS_TOKEN_OUT,
  output logic PROGRAM_DONE_OUT_N
);
  import mqf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // ************************************************************
  // Reset and pin synchronisers
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] ftok_sync_q;
  logic [1:0] etok_sync_q;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ftok_sync_q <= 2'h0;
      etok_sync_q <= 2'h0;
    end
    else
    begin
      ftok_sync_q <= {ftok_sync_q[0], FULL_BUS_TOKEN_IN};
      etok_sync_q <= {etok_sync_q[0], EMPTY_BUS_TOKEN_IN};
    end
  end

  // Tokens are only reported; in direct mode they carry no timing.
  assign FULL_BUS_TOKEN_OUT = 1'b1;
  assign EMPTY_BUS_TOKEN_OUT = 1'b1;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] thresh_q;
  logic [31:0] status;
  logic [31:0] prdata_q;
  logic port_en;
  logic [MQF_DEVW-1:0] dev_id;
  logic [CW-1:0] af_ofs;
  logic [CW-1:0] ae_ofs;
  logic apb_wr;
  logic hit;

  assign port_en = ctrl_q[MQF_CTRL_EN_BIT];
  assign dev_id = ctrl_q[MQF_CTRL_DEV_LSB +: MQF_DEVW];
  assign af_ofs = thresh_q[MQF_THR_AF_LSB +: CW];
  assign ae_ofs = thresh_q[MQF_THR_AE_LSB +: CW];
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign PROGRAM_DONE_OUT_N = !port_en;
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;

  always_comb
  begin
    if (PADDR == MQF_CTRL_OFS)
      hit = 1'b1;
    else if (PADDR == MQF_THRESH_OFS)
      hit = 1'b1;
    else if (PADDR == MQF_STATUS_OFS)
      hit = 1'b1;
    else
      hit = 1'b0;
  end
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= MQF_CTRL_RST;
      thresh_q <= MQF_THRESH_RST;
    end
    else if (apb_wr && PADDR == MQF_CTRL_OFS)
      ctrl_q <= PWDATA;
    else if (apb_wr && PADDR == MQF_THRESH_OFS)
      thresh_q <= PWDATA;
  end

  // Read data is captured in the setup phase so the access phase needs no wait.
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (PSEL && !PENABLE)
    begin
      if (PADDR == MQF_CTRL_OFS)
        prdata_q <= ctrl_q;
      else if (PADDR == MQF_THRESH_OFS)
        prdata_q <= thresh_q;
      else if (PADDR == MQF_STATUS_OFS)
        prdata_q <= status;
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Queue selection
  // ************************************************************
  logic [MQF_QW-1:0] wq_q;
  logic wr_dev_q;
  logic [MQF_QW-1:0] rq_q;
  logic rd_dev_q;
  logic null_q;
  logic [1:0] force_q;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wq_q <= '0;
      wr_dev_q <= 1'b0;
    end
    else if (port_en && WR_REQ.sel)
    begin
      wq_q <= WR_REQ.addr[MQF_QW-1:0];
      wr_dev_q <= WR_REQ.addr[MQF_QW +: MQF_DEVW] == dev_id;
    end
  end

  // The host keeps two cycles between selections, so the fall-through count never restarts early.
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rq_q <= '0;
      rd_dev_q <= 1'b0;
      null_q <= 1'b1;
      force_q <= 2'h0;
    end
    else if (port_en && RD_REQ.sel)
    begin
      rq_q <= RD_REQ.addr[MQF_QW-1:0];
      rd_dev_q <= RD_REQ.addr[MQF_QW +: MQF_DEVW] == dev_id;
      null_q <= RD_REQ.null_q;
      force_q <= MQF_FIRST_WORD_FALL_THROUGH_CYCLES;
    end
    else if (force_q != 2'h0)
      force_q <= force_q - 2'h1;
  end

  // ************************************************************
  // Queue storage
  // ************************************************************
  logic [MQF_DW-1:0] mem [MQF_NQ*DEPTH];
  logic [CW-1:0] cnt_q [MQF_NQ];
  logic [PW-1:0] wp_q [MQF_NQ];
  logic [PW-1:0] rp_q [MQF_NQ];
  logic [MQF_NQ-1:0] empty;
  logic [MQF_NQ-1:0] full;
  logic [MQF_NQ-1:0] af_bits_q;
  logic [MQF_NQ-1:0] ae_bits_q;
  logic push;
  logic pop;
  logic adv;

  assign push = port_en && wr_dev_q && WR_REQ.en && !full[wq_q];

  always_ff @(posedge CLK_SYS)
  begin
    if (push)
      mem[{wq_q, wp_q[wq_q]}] <= WR_REQ.data;
  end

  // Almost bits of each queue are registered from its count, so they trail the access by two edges; empty and full trail it by one.
  for (genvar i = 0; i < MQF_NQ; i++)
  begin : g_queue
    logic push_i;
    logic pop_i;
    assign push_i = push && wq_q == MQF_QW'(i);
    assign pop_i = pop && rq_q == MQF_QW'(i);
    assign empty[i] = cnt_q[i] == '0;
    assign full[i] = cnt_q[i] == FULL_CNT;

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_q[i] <= '0;
        wp_q[i] <= '0;
        rp_q[i] <= '0;
        af_bits_q[i] <= 1'b1;
        ae_bits_q[i] <= 1'b0;
      end
      else
      begin
        cnt_q[i] <= cnt_q[i] + CW'(push_i) - CW'(pop_i);
        wp_q[i] <= wp_q[i] + PW'(push_i);
        rp_q[i] <= rp_q[i] + PW'(pop_i);
        af_bits_q[i] <= cnt_q[i] < FULL_CNT - af_ofs;
        ae_bits_q[i] <= cnt_q[i] > ae_ofs;
      end
    end
  end

  // ************************************************************
  // Read pipeline
  // ************************************************************
  logic s1v_q;
  logic [MQF_DW-1:0] s1d_q;
  logic ovv_q;
  logic [MQF_DW-1:0] out_q;
  logic consume;

  // Forced advances during the two cycles after a selection give fall-through without read enable.
  assign adv = s1v_q && (RD_REQ.en || !ovv_q || force_q != 2'h0);
  assign consume = RD_REQ.en || force_q == 2'h1;
  assign pop = port_en && rd_dev_q && !null_q && !empty[rq_q] && (!s1v_q || adv);

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1v_q <= 1'b0;
      s1d_q <= '0;
    end
    else if (pop)
    begin
      s1v_q <= 1'b1;
      s1d_q <= mem[{rq_q, rp_q[rq_q]}];
    end
    else if (adv)
      s1v_q <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= '0;
      ovv_q <= 1'b0;
    end
    else if (adv)
    begin
      out_q <= s1d_q;
      ovv_q <= 1'b1;
    end
    else if (consume && !s1v_q)
      ovv_q <= 1'b0;
  end

  // ************************************************************
  // Discrete flags
  // ************************************************************
  logic [1:0] af_n_q;
  logic [1:0] ae_n_q;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      af_n_q <= 2'h3;
      ae_n_q <= 2'h0;
    end
    else
    begin
      af_n_q <= {af_n_q[0], (cnt_q[wq_q] < FULL_CNT - af_ofs)};
      ae_n_q <= {ae_n_q[0], (cnt_q[rq_q] > ae_ofs) && !null_q};
    end
  end

  // Output enable bypasses the clock on purpose; only the drive changes, never the stored word.
  assign RD_DATA = out_q;
  assign RD_DATA_OE = !OUT_EN_N && rd_dev_q;
  assign OUTPUT_VALID_N = !ovv_q;
  assign OUTPUT_VALID_N_OE = rd_dev_q;
  assign ALMOST_FULL_N = af_n_q[1];
  assign ALMOST_FULL_N_OE = wr_dev_q;
  assign ALMOST_EMPTY_N = ae_n_q[1];
  assign ALMOST_EMPTY_N_OE = rd_dev_q;

  // ************************************************************
  // Flag busses
  // ************************************************************
  logic fbus_own_q;
  logic ebus_own_q;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fbus_own_q <= 1'b0;
      ebus_own_q <= 1'b0;
    end
    else
    begin
      if (port_en && FULL_BUS_SEL.sel)
        fbus_own_q <= FULL_BUS_SEL.dev == dev_id;
      if (port_en && EMPTY_BUS_SEL.sel)
        ebus_own_q <= EMPTY_BUS_SEL.dev == dev_id;
    end
  end

  assign ALMOST_FULL_QUEUE_BUS = af_bits_q;
  assign ALMOST_FULL_QUEUE_BUS_OE = fbus_own_q;
  assign ALMOST_EMPTY_QUEUE_BUS = ae_bits_q;
  assign ALMOST_EMPTY_QUEUE_BUS_OE = ebus_own_q;

  // ************************************************************
  // Status word
  // ************************************************************
  always_comb
  begin
    status = 32'h0000_0000;
    status[MQF_ST_EMPTY_LSB +: MQF_NQ] = empty;
    status[MQF_ST_FULL_LSB +: MQF_NQ] = full;
    status[MQF_ST_OV_BIT] = ovv_q;
    status[MQF_ST_FTOK_BIT] = ftok_sync_q[1];
    status[MQF_ST_ETOK_BIT] = etok_sync_q[1];
  end

endmodule : mqf_core

`default_nettype wire

//--- core/mqf_pkg.sv
// Package of the multi-queue read and flag block: widths, register map and port carriers.
// Assumes one system clock and an APB master with 32-bit data.
package mqf_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int MQF_NQ = 8;
  localparam int MQF_QW = 3;
  localparam int MQF_DEVW = 3;
  localparam int MQF_DW = 18;
  localparam int MQF_AW = 8;

  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam logic [MQF_AW-1:0] MQF_CTRL_OFS = 8'h00;
  localparam logic [MQF_AW-1:0] MQF_THRESH_OFS = 8'h04;
  localparam logic [MQF_AW-1:0] MQF_STATUS_OFS = 8'h08;
  localparam int MQF_CTRL_DEV_LSB = 0;
  localparam int MQF_CTRL_EN_BIT = 8;
  localparam int MQF_THR_AF_LSB = 0;
  localparam int MQF_THR_AE_LSB = 16;
  localparam int MQF_ST_EMPTY_LSB = 0;
  localparam int MQF_ST_FULL_LSB = 8;
  localparam int MQF_ST_OV_BIT = 16;
  localparam int MQF_ST_FTOK_BIT = 17;
  localparam int MQF_ST_ETOK_BIT = 18;
  localparam logic [31:0] MQF_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MQF_THRESH_RST = 32'h0002_0002;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [1:0] MQF_FIRST_WORD_FALL_THROUGH_CYCLES = 2'h2;
  localparam int MQF_RD_SEL_GAP = 2;

  // ************************************************************
  // Port carriers
  // ************************************************************
  typedef struct packed {
    logic sel;
    logic [MQF_DEVW+MQF_QW-1:0] addr;
    logic en;
    logic [MQF_DW-1:0] data;
  } mqf_wr_req_t;

  typedef struct packed {
    logic sel;
    logic null_q;
    logic [MQF_DEVW+MQF_QW-1:0] addr;
    logic en;
  } mqf_rd_req_t;

  typedef struct packed {
    logic sel;
    logic [MQF_DEVW-1:0] dev;
  } mqf_bus_sel_t;

endpackage : mqf_pkg

//--- test/mqf_core_sva.sv
// Assertion checker for the multi-queue read and flag block.
// Assumes it is bound to mqf_core and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module mqf_core_sva
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Ports watched
  input wire mqf_pkg::mqf_wr_req_t WR_REQ,
  input wire logic ALMOST_FULL_N,
  input wire mqf_pkg::mqf_rd_req_t RD_REQ,
  input wire logic OUT_EN_N,
  input wire logic [mqf_pkg::MQF_DW-1:0] RD_DATA,
  input wire logic RD_DATA_OE,
  input wire logic OUTPUT_VALID_N,
  input wire logic OUTPUT_VALID_N_OE,
  input wire mqf_pkg::mqf_bus_sel_t FULL_BUS_SEL,
  input wire mqf_pkg::mqf_bus_sel_t EMPTY_BUS_SEL,
  input wire logic ALMOST_FULL_QUEUE_BUS_OE,
  input wire logic ALMOST_EMPTY_QUEUE_BUS_OE
);
  import mqf_pkg::*;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  oe_async_a: assert property (RD_DATA_OE |-> !OUT_EN_N && OUTPUT_VALID_N_OE)
    else $error("data bus on while disabled");
  // Excludes the two edges after a select, where fall-through moves words without read enable.
  rd_hold_a: assert property (!OUTPUT_VALID_N && !RD_REQ.en && !$past(RD_REQ.sel) && !$past(RD_REQ.sel, 2)
    |=> $stable(RD_DATA)) else $error("word moved without read");
  ov_valid_a: assert property ($fell(OUTPUT_VALID_N) |-> $changed(RD_DATA))
    else $error("valid without new word");
  ov_keep_a: assert property ($rose(OUTPUT_VALID_N) |-> $stable(RD_DATA))
    else $error("word lost on empty");
  null_q_a: assert property (RD_REQ.sel && RD_REQ.null_q |-> ##3 OUTPUT_VALID_N && $stable(RD_DATA))
    else $error("null queue not empty");
  af_cause_a: assert property ($fell(ALMOST_FULL_N) |-> $past(WR_REQ.en, 3) || $past(WR_REQ.sel, 3))
    else $error("almost full latency");
  afbus_sel_a: assert property ($changed(ALMOST_FULL_QUEUE_BUS_OE) |-> $past(FULL_BUS_SEL.sel))
    else $error("full bus owner change");
  aebus_sel_a: assert property ($changed(ALMOST_EMPTY_QUEUE_BUS_OE) |-> $past(EMPTY_BUS_SEL.sel))
    else $error("empty bus owner change");
endmodule : mqf_core_sva
bind mqf_core mqf_core_sva u_mqf_core_sva
(
  .CLK_SYS(CLK_SYS), .NRST(NRST), .WR_REQ(WR_REQ), .ALMOST_FULL_N(ALMOST_FULL_N), .RD_REQ(RD_REQ),
  .OUT_EN_N(OUT_EN_N), .RD_DATA(RD_DATA), .RD_DATA_OE(RD_DATA_OE), .OUTPUT_VALID_N(OUTPUT_VALID_N),
  .OUTPUT_VALID_N_OE(OUTPUT_VALID_N_OE), .FULL_BUS_SEL(FULL_BUS_SEL), .EMPTY_BUS_SEL(EMPTY_BUS_SEL),
  .ALMOST_FULL_QUEUE_BUS_OE(ALMOST_FULL_QUEUE_BUS_OE), .ALMOST_EMPTY_QUEUE_BUS_OE(ALMOST_EMPTY_QUEUE_BUS_OE)
);
`default_nettype wire

//--- test/mqf_host_model.sv
// Host model: write controller, read controller and flag bus selector.
// Assumes calls come from one bench process; each task starts at the next rising edge.
`timescale 1ns/100ps
`default_nettype none
module mqf_host_model
(
  // Clock
  input wire logic clk_sys,
  // Requests
  output var mqf_pkg::mqf_wr_req_t wr_req,
  output var mqf_pkg::mqf_rd_req_t rd_req,
  output var mqf_pkg::mqf_bus_sel_t full_sel,
  output var mqf_pkg::mqf_bus_sel_t empty_sel,
  // Straps
  output logic tok_full,
  output logic tok_empty
);
  import mqf_pkg::*;
  // A lone device is the chain master, so both token inputs are tied low.
  assign tok_full = 1'b0;
  assign tok_empty = 1'b0;
  initial
  begin
    wr_req = '0;
    rd_req = '0;
    full_sel = '0;
    empty_sel = '0;
  end
  task automatic wsel(input logic [5:0] a);
    @(posedge clk_sys);
    wr_req.sel <= 1'b1;
    wr_req.addr <= a;
    @(posedge clk_sys);
    wr_req.sel <= 1'b0;
  endtask : wsel
  // Released data is inverted, so a late sample picks up a wrong word.
  task automatic wr(input logic [17:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      wr_req.en <= 1'b1;
      wr_req.data <= d + 18'(i);
    end
    @(posedge clk_sys);
    wr_req.en <= 1'b0;
    wr_req.data <= ~wr_req.data;
  endtask : wr
  task automatic rsel(input logic [5:0] a, input logic nq);
    @(posedge clk_sys);
    rd_req.sel <= 1'b1;
    rd_req.null_q <= nq;
    rd_req.addr <= a;
    @(posedge clk_sys);
    rd_req.sel <= 1'b0;
    @(posedge clk_sys);
  endtask : rsel
  task automatic ren;
    @(posedge clk_sys);
    rd_req.en <= 1'b1;
    @(posedge clk_sys);
    rd_req.en <= 1'b0;
  endtask : ren
  task automatic bsel(input logic [2:0] d);
    @(posedge clk_sys);
    full_sel <= {1'b1, d};
    empty_sel <= {1'b1, d};
    @(posedge clk_sys);
    full_sel <= '0;
    empty_sel <= '0;
  endtask : bsel
endmodule : mqf_host_model
`default_nettype wire

//--- test/mqf_core_tb.sv
// Self-checking bench for the multi-queue read and flag block.
// Assumes DEPTH 16 and the reset thresholds of two words.
`timescale 1ns/100ps
`default_nettype none
module mqf_core_tb;
  import mqf_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, out_en_n, e;
  logic rd_oe, ov_n, af_n, af_oe, afb_oe, aeb_oe, done_n, tok_f, tok_e;
  logic ov_oe, ae_n, ae_oe, tok_fo, tok_eo;
  logic [7:0] paddr, afb, aeb;
  logic [31:0] pwdata, prdata, r;
  logic [17:0] rd_data;
  mqf_wr_req_t wr_req;
  mqf_rd_req_t rd_req;
  mqf_bus_sel_t full_sel, empty_sel;
  int num_errors = 0;
  int checked = 0;
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  mqf_core #(.DEPTH(16)) u_mqf_core
  (
    .CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WR_REQ(wr_req),
    .ALMOST_FULL_N(af_n), .ALMOST_FULL_N_OE(af_oe), .RD_REQ(rd_req), .OUT_EN_N(out_en_n),
    .RD_DATA(rd_data), .RD_DATA_OE(rd_oe), .OUTPUT_VALID_N(ov_n), .OUTPUT_VALID_N_OE(ov_oe),
    .ALMOST_EMPTY_N(ae_n), .ALMOST_EMPTY_N_OE(ae_oe), .FULL_BUS_SEL(full_sel), .EMPTY_BUS_SEL(empty_sel),
    .ALMOST_FULL_QUEUE_BUS(afb), .ALMOST_FULL_QUEUE_BUS_OE(afb_oe), .ALMOST_EMPTY_QUEUE_BUS(aeb),
    .ALMOST_EMPTY_QUEUE_BUS_OE(aeb_oe), .FULL_BUS_TOKEN_IN(tok_f), .EMPTY_BUS_TOKEN_IN(tok_e),
    .FULL_BUS_TOKEN_OUT(tok_fo), .EMPTY_BUS_TOKEN_OUT(tok_eo), .PROGRAM_DONE_OUT_N(done_n)
  );
  mqf_host_model u_mqf_host_model
  (
    .clk_sys(clk_sys), .wr_req(wr_req), .rd_req(rd_req), .full_sel(full_sel), .empty_sel(empty_sel),
    .tok_full(tok_f), .tok_empty(tok_e)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : cyc
  task automatic test_done;
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, out_en_n} = '0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, MQF_CTRL_OFS, 32'h0000_0000);
    chk(r, MQF_CTRL_RST, "ctrl rst");
    chk({26'h0, done_n, tok_fo, tok_eo, ov_n, af_n, ae_n}, 32'h0000_003E, "reset outs");
    apb(1'b0, MQF_THRESH_OFS, 32'h0000_0000);
    chk(r, MQF_THRESH_RST, "thr rst");
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001, "unmapped err");
    apb(1'b1, MQF_CTRL_OFS, 32'h0000_0100);
    apb(1'b0, MQF_CTRL_OFS, 32'h0000_0000);
    chk(r, 32'h0000_0100, "ctrl");
    chk({31'h0, done_n}, 32'h0000_0000, "prog done");
    u_mqf_host_model.bsel(3'h0);
    cyc(0);
    chk({31'h0, afb_oe}, 32'h0000_0001, "af bus oe");
    chk({31'h0, aeb_oe}, 32'h0000_0001, "ae bus oe");
    u_mqf_host_model.wsel(6'h01);
    u_mqf_host_model.wr(18'h0_0010, 3);
    cyc(3);
    chk({24'h0, aeb}, 32'h0000_0002, "ae bus");
    u_mqf_host_model.rsel(6'h01, 1'b0);
    cyc(1);
    chk({14'h0, rd_data}, 32'h0000_0010, "first word");
    chk({31'h0, ov_n}, 32'h0000_0000, "valid");
    chk({31'h0, ae_n}, 32'h0000_0001, "ae new q");
    cyc(3);
    chk({14'h0, rd_data}, 32'h0000_0010, "hold");
    chk({31'h0, rd_oe}, 32'h0000_0001, "bus on");
    chk({30'h0, ov_oe, ae_oe}, 32'h0000_0003, "read oe");
    chk({31'h0, ae_n}, 32'h0000_0000, "ae set");
    for (int i = 1; i < 3; i++)
    begin
      u_mqf_host_model.ren();
      cyc(0);
      chk({14'h0, rd_data}, 32'h0000_0010 + i, "next word");
    end
    u_mqf_host_model.ren();
    cyc(1);
    chk({31'h0, ov_n}, 32'h0000_0001, "drained");
    chk({14'h0, rd_data}, 32'h0000_0012, "last kept");
    u_mqf_host_model.wr(18'h0_0020, 3);
    cyc(4);
    chk({14'h0, rd_data}, 32'h0000_0020, "refill");
    u_mqf_host_model.rsel(6'h00, 1'b1);
    cyc(1);
    chk({31'h0, ov_n}, 32'h0000_0001, "null empty");
    chk({14'h0, rd_data}, 32'h0000_0021, "pipe word");
    u_mqf_host_model.rsel(6'h01, 1'b0);
    cyc(1);
    chk({14'h0, rd_data}, 32'h0000_0022, "no loss");
    u_mqf_host_model.wsel(6'h02);
    u_mqf_host_model.wr(18'h0_0100, 13);
    cyc(3);
    chk({30'h0, af_oe, af_n}, 32'h0000_0003, "below af");
    u_mqf_host_model.wr(18'h0_0200, 1);
    cyc(1);
    chk({31'h0, af_n}, 32'h0000_0001, "af early");
    cyc(1);
    chk({31'h0, af_n}, 32'h0000_0000, "af set");
    u_mqf_host_model.wsel(6'h01);
    cyc(1);
    chk({31'h0, af_n}, 32'h0000_0000, "af old q");
    cyc(1);
    chk({31'h0, af_n}, 32'h0000_0001, "af new q");
    chk({24'h0, afb}, 32'h0000_00FB, "af bus");
    u_mqf_host_model.wr(18'h0_0030, 4);
    cyc(1);
    chk({31'h0, ae_n}, 32'h0000_0000, "ae early");
    cyc(1);
    chk({31'h0, ae_n}, 32'h0000_0001, "ae clear");
    @(posedge clk_sys);
    out_en_n <= 1'b1;
    #1;
    chk({31'h0, rd_oe}, 32'h0000_0000, "bus off");
    chk({14'h0, rd_data}, 32'h0000_0022, "word kept");
    u_mqf_host_model.rsel(6'h02, 1'b0);
    cyc(1);
    chk({14'h0, rd_data}, 32'h0000_0100, "q2 first");
    chk({24'h0, afb}, 32'h0000_00FF, "af bus read");
    u_mqf_host_model.bsel(3'h1);
    cyc(0);
    chk({30'h0, afb_oe, aeb_oe}, 32'h0000_0000, "bus release");
    test_done();
  end
  // The sequence needs little over a hundred cycles; this bound only catches a hang.
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
endmodule : mqf_core_tb
`default_nettype wire
